// >>> verilog/gco_defs.vh
`ifndef GCO_DEFS_VH
`define GCO_DEFS_VH

// Register indexes; the byte address on the bus is four times the index.
`define GCO_IDX_NUM_LO 6'h28
`define GCO_IDX_NUM_HI 6'h29
`define GCO_IDX_DEN_LO 6'h2A
`define GCO_IDX_DEN_HI 6'h2B
`define GCO_IDX_CLK1 6'h2C
`define GCO_IDX_CLK2 6'h2D
`define GCO_IDX_CLK3 6'h2E
`define GCO_IDX_TRI 6'h2F

// Byte-address split of the bus address.
`define GCO_ADDR_IDX_HI 7
`define GCO_ADDR_IDX_LO 2
`define GCO_ADDR_ALIGN 2'b00

// Fields of the phase and divider words.
`define GCO_F_HALF 0
`define GCO_F_QUARTER 1
`define GCO_F_PHASE_LO 2
`define GCO_F_PHASE_HI 5
`define GCO_F_DRIVE 6
`define GCO_F_TRI_HI 1
`define GCO_F_TRI_LO 0

// Divider select codes, written as {quarter, half}.
`define GCO_DIV_FULL 2'b00
`define GCO_DIV_HALF 2'b01
`define GCO_DIV_QUARTER 2'b10
`define GCO_DIV_BOTH 2'b11

// Tristate code and reset values.
`define GCO_TRI_HIGHZ 2'b11
`define GCO_TRI_RESET 2'b00
`define GCO_CTRL_RESET 7'h00
`define GCO_RATIO_RESET 32'h0000_0000

// Divider counter values at which the half and quarter rate clocks toggle, and the counter step.
`define GCO_CNT_HALF_TOGGLE 1'b1
`define GCO_CNT_QUARTER_TOGGLE 2'b11
`define GCO_CNT_ONE 2'b01

// Nominal phase step in picoseconds; one tap of the delay line stands for it.
`define GCO_PHASE_STEP_PS 700

`endif

// >>> verilog/gco_clock_ctrl.v
`include "gco_defs.vh"

module gco_clock_ctrl #(
  parameter PHASE_W = 4,
  parameter RATIO_W = 32,
  parameter HALF_W = 16,
  parameter [31:0] DEF_NUM_STD0 = 32'h0000_0001,
  parameter [31:0] DEF_DEN_STD0 = 32'h0000_0001,
  parameter [31:0] DEF_NUM_STD1 = 32'h0000_0002,
  parameter [31:0] DEF_DEN_STD1 = 32'h0000_0001,
  parameter [31:0] DEF_NUM_STD2 = 32'h0000_0003,
  parameter [31:0] DEF_DEN_STD2 = 32'h0000_0002,
  parameter [31:0] DEF_NUM_STD3 = 32'h0000_0004,
  parameter [31:0] DEF_DEN_STD3 = 32'h0000_0003
) (
  // Clock and reset.
  input wire i_clk,
  input wire i_rst_n,
  // APB slave.
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  // Video timing inputs from logic on the same clock.
  input wire [1:0] i_video_std,
  input wire i_video_tick,
  input wire i_line_sync,
  // Genlock ratio.
  output wire [31:0] o_genlock_numerator,
  output wire [31:0] o_genlock_denominator,
  output wire o_ratio_written,
  // Pixel clock outputs.
  output wire o_first_pixel_clock_out,
  output wire o_first_clock_drive_strength,
  output wire o_second_pixel_clock_out,
  output wire o_second_clock_drive_strength,
  output wire o_differential_pixel_clock_out_p,
  output wire o_differential_pixel_clock_out_n,
  output wire o_differential_pixel_clock_out_oe
);

  localparam NCH = 3;
  localparam TAPS = 1 << PHASE_W;

  // Reset release through two flip-flops.
  reg rst_meta_q;
  reg rst_sync_q;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  wire rst_n = rst_sync_q;

  // Bus timing, as software sees it.
  //
  // Every transfer is one setup cycle and exactly one access cycle. The
  // slave answers in the first access cycle, so a master never waits
  // longer than that. Read data is chosen from the address in the setup
  // cycle and captured into a flip-flop on that edge. That costs nothing
  // in latency, since the access cycle has to come anyway. It also keeps
  // the read path out of the bus timing.
  //
  // A write lands on the edge that closes the access cycle. The error
  // flag is decided in setup, so a refused write never reaches the
  // storage, not even for one cycle.
  //
  // Refused transfers are those to an index outside the eight words of
  // this block, or to a byte address that is not word aligned. They
  // answer with the error flag and zero read data, and change nothing.
  //
  // Back-to-back transfers are accepted. The next setup may follow the
  // access cycle at once, because the ready flop only looks at the
  // current setup cycle.
  //
  // The upper half of every read word is zero. Only the defined fields
  // of the control words are stored, so reserved bits read back as zero
  // whatever was written to them.
  //
  // Each half of a ratio is written on its own and takes effect at once.
  // Software that changes both halves of a live ratio passes through one
  // mixed value; if that matters it should change the low half last.
  // There is no shadow register, which keeps the write path simple.

  // Register storage. Only defined bits are kept; reserved bits read zero.
  reg [RATIO_W-1:0] num_q;
  reg [RATIO_W-1:0] den_q;
  reg [6:0] ctrl_q [0:NCH-1];
  reg [1:0] tri_q;
  reg [1:0] std_q;
  reg defaults_done_q;
  reg ratio_wr_q;
  reg [31:0] prdata_q;
  reg pready_q;
  reg pslverr_q;

  wire [5:0] idx = i_paddr[`GCO_ADDR_IDX_HI:`GCO_ADDR_IDX_LO];
  wire aligned = (i_paddr[1:0] == `GCO_ADDR_ALIGN);
  wire setup = i_psel && !i_penable;
  wire access = i_psel && i_penable && pready_q;
  wire wr = access && i_pwrite && !pslverr_q;

  function mapped;
    input [5:0] a;
    begin
      mapped = (a >= `GCO_IDX_NUM_LO) && (a <= `GCO_IDX_TRI);
    end
  endfunction

  // Default ratio for each output standard.
  function [2*RATIO_W-1:0] std_ratio;
    input [1:0] s;
    begin
      case (s)
        2'b00: std_ratio = {DEF_NUM_STD0, DEF_DEN_STD0};
        2'b01: std_ratio = {DEF_NUM_STD1, DEF_DEN_STD1};
        2'b10: std_ratio = {DEF_NUM_STD2, DEF_DEN_STD2};
        default: std_ratio = {DEF_NUM_STD3, DEF_DEN_STD3};
      endcase
    end
  endfunction

  wire [2*RATIO_W-1:0] def_ratio = std_ratio(i_video_std);
  // Defaults load once after reset and again whenever the standard changes.
  wire load_defaults = !defaults_done_q || (i_video_std != std_q);

  // Read data is captured in the setup cycle so it leaves a flip-flop.
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0000_0000;
    case (idx)
      `GCO_IDX_NUM_LO: rd_d[HALF_W-1:0] = num_q[HALF_W-1:0];
      `GCO_IDX_NUM_HI: rd_d[HALF_W-1:0] = num_q[RATIO_W-1:HALF_W];
      `GCO_IDX_DEN_LO: rd_d[HALF_W-1:0] = den_q[HALF_W-1:0];
      `GCO_IDX_DEN_HI: rd_d[HALF_W-1:0] = den_q[RATIO_W-1:HALF_W];
      `GCO_IDX_CLK1: rd_d[6:0] = ctrl_q[0];
      `GCO_IDX_CLK2: rd_d[6:0] = ctrl_q[1];
      `GCO_IDX_CLK3: rd_d[5:0] = ctrl_q[2][5:0];
      `GCO_IDX_TRI: rd_d[1:0] = tri_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= !(aligned && mapped(idx));
        prdata_q <= (aligned && mapped(idx)) ? rd_d : 32'h0000_0000;
      end
    end
  end

  // Genlock ratio registers; a host write wins over a default reload.
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      num_q <= `GCO_RATIO_RESET;
      den_q <= `GCO_RATIO_RESET;
      std_q <= 2'b00;
      defaults_done_q <= 1'b0;
      ratio_wr_q <= 1'b0;
    end else begin
      std_q <= i_video_std;
      defaults_done_q <= 1'b1;
      ratio_wr_q <= 1'b0;
      if (load_defaults) begin
        num_q <= def_ratio[2*RATIO_W-1:RATIO_W];
        den_q <= def_ratio[RATIO_W-1:0];
      end
      if (wr) begin
        case (idx)
          `GCO_IDX_NUM_LO: num_q[HALF_W-1:0] <= i_pwdata[HALF_W-1:0];
          `GCO_IDX_NUM_HI: num_q[RATIO_W-1:HALF_W] <= i_pwdata[HALF_W-1:0];
          `GCO_IDX_DEN_LO: den_q[HALF_W-1:0] <= i_pwdata[HALF_W-1:0];
          `GCO_IDX_DEN_HI: den_q[RATIO_W-1:HALF_W] <= i_pwdata[HALF_W-1:0];
          default: ;
        endcase
        // A manual lock is the host loading its own ratio.
        if (idx >= `GCO_IDX_NUM_LO && idx <= `GCO_IDX_DEN_HI) begin
          ratio_wr_q <= 1'b1;
        end
      end
    end
  end

  // Control words. Bits that are reserved are dropped, so a stray one does no harm.
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q[0] <= `GCO_CTRL_RESET;
      ctrl_q[1] <= `GCO_CTRL_RESET;
      ctrl_q[2] <= `GCO_CTRL_RESET;
      tri_q <= `GCO_TRI_RESET;
    end else if (wr) begin
      case (idx)
        `GCO_IDX_CLK1: ctrl_q[0] <= i_pwdata[6:0];
        `GCO_IDX_CLK2: ctrl_q[1] <= i_pwdata[6:0];
        `GCO_IDX_CLK3: ctrl_q[2] <= {1'b0, i_pwdata[5:0]};
        `GCO_IDX_TRI: tri_q <= i_pwdata[`GCO_F_TRI_HI:`GCO_F_TRI_LO];
        default: ;
      endcase
    end
  end

  // Pixel clock timing, as a downstream device sees it.
  //
  // Each channel has a two-bit tick counter, a divided clock flop, a tap
  // line of one flop per phase step and an output flop. The output pin
  // therefore follows the divided clock by the phase setting plus two
  // cycles of the system clock.
  //
  // The line sync pulse clears every counter and divided clock in the
  // same cycle. All three channels then start from one common point, and
  // their skew against each other is set only by the phase fields.
  //
  // A change of divider takes effect on the next tick, a change of phase or of hold_low on the next system clock edge. The tap
  // line is not flushed, so a short pulse or a missing edge can appear on
  // the pin right after the change. Downstream logic that cannot bear a
  // glitch should be held off until the next line sync.
  //
  // The two single-ended clocks stop low when both divider bits are set.
  // The differential pair keeps running at the full rate in that case,
  // which is why the stop term leaves out the last channel.
  //
  // The pair has no drive-strength control. Its high impedance state is
  // set only by the two-bit field, and only the code with both bits set
  // releases the pins; the other three codes keep them driven.
  //
  // In the full setting the clock toggles on every tick, so its rate is half the tick rate. The phase
  // delay line uses one i_clk cycle per nominal step; a real pad would use
  // analogue taps, which this logic cannot model.
  wire [NCH-1:0] pclk_q;
  reg drive1_q;
  reg drive2_q;
  reg diff_n_q;
  reg diff_oe_q;

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_ch
      reg [1:0] cnt_q;
      reg div_clk_q;
      reg [TAPS-1:0] dly_q;
      wire [1:0] div_sel = {ctrl_q[ch][`GCO_F_QUARTER], ctrl_q[ch][`GCO_F_HALF]};
      wire [PHASE_W-1:0] phase = ctrl_q[ch][`GCO_F_PHASE_HI:`GCO_F_PHASE_LO];
      // Both bits set: single-ended clocks stop, the differential one runs full.
      wire hold_low = (div_sel == `GCO_DIV_BOTH) && (ch != NCH - 1);
      reg toggle;
      reg out_q;

      // Each channel keeps its own output flop, so every bit has one driver.
      assign pclk_q[ch] = out_q;

      always @* begin
        toggle = 1'b0;
        case (div_sel)
          `GCO_DIV_FULL: toggle = 1'b1;
          `GCO_DIV_HALF: toggle = (cnt_q[0] == `GCO_CNT_HALF_TOGGLE);
          `GCO_DIV_QUARTER: toggle = (cnt_q == `GCO_CNT_QUARTER_TOGGLE);
          `GCO_DIV_BOTH: toggle = (ch == NCH - 1);
          default: toggle = 1'b0;
        endcase
      end

      // Line sync restarts every divider so the clocks keep a fixed phase
      // to the timing outputs.
      always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt_q <= 2'b00;
          div_clk_q <= 1'b0;
        end else if (i_line_sync) begin
          cnt_q <= 2'b00;
          div_clk_q <= 1'b0;
        end else if (i_video_tick) begin
          cnt_q <= cnt_q + `GCO_CNT_ONE;
          if (toggle) begin
            div_clk_q <= ~div_clk_q;
          end
        end
      end

      always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          dly_q <= {TAPS{1'b0}};
          out_q <= 1'b0;
        end else begin
          dly_q <= {dly_q[TAPS-2:0], div_clk_q};
          out_q <= hold_low ? 1'b0 : dly_q[phase];
        end
      end
    end
  endgenerate

  // The drive bits and the pair controls pass one flop, so every pin of the
  // block leaves a flip-flop. The drive bits reach the pads one cycle after
  // the write, which is harmless since they only set pad strength.
  //
  // The inverted half of the pair is taken from the same tap as the true
  // half. Both halves then carry the same delay and stay complementary.
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive1_q <= 1'b0;
      drive2_q <= 1'b0;
      diff_n_q <= 1'b1;
      diff_oe_q <= 1'b1;
    end else begin
      drive1_q <= ctrl_q[0][`GCO_F_DRIVE];
      drive2_q <= ctrl_q[1][`GCO_F_DRIVE];
      diff_n_q <= ~g_ch[NCH-1].dly_q[g_ch[NCH-1].phase];
      diff_oe_q <= (tri_q != `GCO_TRI_HIGHZ);
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_genlock_numerator = num_q;
  assign o_genlock_denominator = den_q;
  assign o_ratio_written = ratio_wr_q;
  assign o_first_pixel_clock_out = pclk_q[0];
  assign o_first_clock_drive_strength = drive1_q;
  assign o_second_pixel_clock_out = pclk_q[1];
  assign o_second_clock_drive_strength = drive2_q;
  assign o_differential_pixel_clock_out_p = pclk_q[2];
  assign o_differential_pixel_clock_out_n = diff_n_q;
  assign o_differential_pixel_clock_out_oe = diff_oe_q;

endmodule

// >>> test/gco_pclk_sink.sv
module gco_pclk_sink (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Pixel clock under watch.
  input wire logic i_pclk,
  output logic [15:0] o_period,
  output logic [15:0] o_stamp
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] now_q;
  logic last_q;
  // A floating pin counts as low, so a released pair shows no edges.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      now_q <= 16'h0000;
      last_q <= 1'b0;
      o_period <= 16'h0000;
      o_stamp <= 16'h0000;
    end else begin
      now_q <= now_q + 16'h0001;
      last_q <= (i_pclk === 1'b1);
      if (i_pclk === 1'b1 && !last_q) begin
        o_period <= now_q - o_stamp;
        o_stamp <= now_q;
      end
    end
  end
endmodule

// >>> test/gco_clock_ctrl_chk.sv
module gco_clock_ctrl_chk (
  // Clock, reset and bus.
  input wire i_clk,
  input wire i_rst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire o_pready,
  // Watched outputs.
  input wire [31:0] o_genlock_numerator,
  input wire [31:0] o_genlock_denominator,
  input wire o_first_pixel_clock_out,
  input wire o_first_clock_drive_strength,
  input wire o_second_pixel_clock_out,
  input wire o_ratio_written,
  input wire o_differential_pixel_clock_out_p,
  input wire o_differential_pixel_clock_out_n,
  input wire o_differential_pixel_clock_out_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  wire wr = i_psel && i_penable && o_pready && i_pwrite;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  property p_num_lo;
    wr && i_paddr == 8'hA0 |=> o_genlock_numerator[15:0] == $past(i_pwdata[15:0]);
  endproperty
  a_num_lo: assert property (p_num_lo) else $error("num low");
  property p_num_hi;
    wr && i_paddr == 8'hA4 |=> o_genlock_numerator[31:16] == $past(i_pwdata[15:0]);
  endproperty
  a_num_hi: assert property (p_num_hi) else $error("num high");
  property p_den_lo;
    wr && i_paddr == 8'hA8 |=> o_genlock_denominator[15:0] == $past(i_pwdata[15:0]);
  endproperty
  a_den_lo: assert property (p_den_lo) else $error("den low");
  property p_den_hi;
    wr && i_paddr == 8'hAC |=> o_genlock_denominator[31:16] == $past(i_pwdata[15:0]);
  endproperty
  a_den_hi: assert property (p_den_hi) else $error("den high");
  // Three cycles only, since the next write may follow that soon.
  property p_hold1;
    wr && i_paddr == 8'hB0 && i_pwdata[1:0] == 2'b11 |-> ##2 !o_first_pixel_clock_out [*3];
  endproperty
  a_hold1: assert property (p_hold1) else $error("clock one not held");
  property p_hold2;
    wr && i_paddr == 8'hB4 && i_pwdata[1:0] == 2'b11 |-> ##2 !o_second_pixel_clock_out [*3];
  endproperty
  a_hold2: assert property (p_hold2) else $error("clock two not held");
  property p_hiz;
    wr && i_paddr == 8'hBC |-> ##2 o_differential_pixel_clock_out_oe == ($past(i_pwdata[1:0], 2) != 2'b11);
  endproperty
  a_hiz: assert property (p_hiz) else $error("pair enable wrong");
  property p_drv1;
    wr && i_paddr == 8'hB0 |-> ##2 o_first_clock_drive_strength == $past(i_pwdata[6], 2);
  endproperty
  a_drv1: assert property (p_drv1) else $error("drive one wrong");
  property p_ratio_wr;
    wr && i_paddr >= 8'hA0 && i_paddr <= 8'hAC && i_paddr[1:0] == 2'b00 |=> o_ratio_written;
  endproperty
  a_ratio_wr: assert property (p_ratio_wr) else $error("ratio write pulse missing");
  property p_diff_n;
    o_differential_pixel_clock_out_n == !o_differential_pixel_clock_out_p;
  endproperty
  a_diff_n: assert property (p_diff_n) else $error("pair not complementary");
  c_hiz: cover property (wr && i_paddr == 8'hBC && i_pwdata[1:0] == 2'b11);
  c_hold: cover property (wr && i_paddr == 8'hB0 && i_pwdata[1:0] == 2'b11);
  c_num: cover property (wr && i_paddr == 8'hA4);
endmodule

bind gco_clock_ctrl gco_clock_ctrl_chk i_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_pready(o_pready), .o_genlock_numerator(o_genlock_numerator),
  .o_genlock_denominator(o_genlock_denominator),
  .o_first_pixel_clock_out(o_first_pixel_clock_out),
  .o_first_clock_drive_strength(o_first_clock_drive_strength),
  .o_second_pixel_clock_out(o_second_pixel_clock_out),
  .o_ratio_written(o_ratio_written),
  .o_differential_pixel_clock_out_p(o_differential_pixel_clock_out_p),
  .o_differential_pixel_clock_out_n(o_differential_pixel_clock_out_n),
  .o_differential_pixel_clock_out_oe(o_differential_pixel_clock_out_oe));

// >>> test/gco_clock_ctrl_test.sv
module gco_clock_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, psel, pen, pwr, tick, lsync, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  logic [1:0] std;
  wire [31:0] prdata, num, den;
  wire pready, pslverr, c1, c2, dp, doe, dr1, dr2, rwr, dn;
  wire dpin = doe ? dp : 1'bz;
  wire [2:0] pins = {dpin, c2, c1};
  wire [15:0] per [3];
  wire [15:0] stp [3];
  int miscompares = 0;
  int n_checks = 0;
  int tdiv = 1;
  int tcnt = 0;
  gco_clock_ctrl i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_video_std(std), .i_video_tick(tick), .i_line_sync(lsync),
    .o_genlock_numerator(num), .o_genlock_denominator(den), .o_ratio_written(rwr),
    .o_first_pixel_clock_out(c1), .o_first_clock_drive_strength(dr1),
    .o_second_pixel_clock_out(c2), .o_second_clock_drive_strength(dr2),
    .o_differential_pixel_clock_out_p(dp), .o_differential_pixel_clock_out_n(dn),
    .o_differential_pixel_clock_out_oe(doe));
  for (genvar k = 0; k < 3; k++) begin : g_sink
    gco_pclk_sink i_sink (.i_clk(clk), .i_rst_n(rst_n), .i_pclk(pins[k]), .o_period(per[k]),
      .o_stamp(stp[k]));
  end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    tcnt <= (tcnt + 1) % tdiv;
    tick <= (tcnt == tdiv - 1);
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk("pready", 32'h0000_0001, 32'(pready));
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk("prdata", e, rd);
  endtask
  task automatic t_reset;
    rdchk(8'hA0, 32'h0000_0001);
    rdchk(8'hA8, 32'h0000_0001);
    rdchk(8'hBC, 32'h0000_0000);
    chk("oe", 32'h0000_0001, 32'(doe));
    std <= 2'b10;
    cyc(4);
    chk("num", 32'h0000_0003, num);
    chk("den", 32'h0000_0002, den);
    $display("t_reset done");
  endtask
  task automatic t_ratio;
    apb(1'b1, 8'hA0, 32'h0000_5A3C);
    apb(1'b1, 8'hA4, 32'h0000_C001);
    apb(1'b1, 8'hA8, 32'h0000_FFFF);
    apb(1'b1, 8'hAC, 32'h0000_8000);
    cyc(1);
    chk("num", 32'hC001_5A3C, num);
    chk("den", 32'h8000_FFFF, den);
    chk("ratio_wr", 32'h0000_0001, 32'(rwr));
    rdchk(8'hA4, 32'h0000_C001);
    chk("ratio_wr", 32'h0000_0000, 32'(rwr));
    rdchk(8'hAA, 32'h0000_0000);
    chk("pslverr", 32'h0000_0001, 32'(er));
    $display("t_ratio done");
  endtask
  task automatic t_div;
    logic [15:0] s0;
    for (int r = 0; r < 3; r++) begin
      for (int c = 0; c < 4; c++) begin
        apb(1'b1, 8'hB0 + 8'(4 * r), 32'(c));
        cyc(40);
        s0 = stp[r];
        cyc(20);
        if (c == 3 && r < 2) chk("held", 32'(s0), 32'(stp[r]));
        else chk("period", 32'(c == 3 ? 2 : 2 << c), 32'(per[r]));
      end
    end
    $display("t_div done");
  endtask
  task automatic t_hiz;
    apb(1'b1, 8'hB0, 32'h0000_0040);
    apb(1'b1, 8'hB4, 32'h0000_0040);
    apb(1'b1, 8'hBC, 32'h0000_0003);
    cyc(2);
    chk("drive1", 32'h0000_0001, 32'(dr1));
    chk("drive2", 32'h0000_0001, 32'(dr2));
    chk("oe", 32'h0000_0000, 32'(doe));
    apb(1'b1, 8'hBC, 32'h0000_0002);
    cyc(2);
    chk("oe", 32'h0000_0001, 32'(doe));
    $display("t_hiz done");
  endtask
  task automatic t_phase;
    int p;
    // Slow ticks give a 32-cycle period, so every skew of 0 to 15 taps is visible.
    tdiv = 16;
    for (int i = 0; i < 3; i++) begin
      p = i * 7 + 1;
      apb(1'b1, 8'hB0, 32'(p << 2));
      apb(1'b1, 8'hB4, 32'((p / 2) << 2));
      apb(1'b1, 8'hB8, 32'((15 - p) << 2));
      lsync <= 1'b1;
      cyc(1);
      lsync <= 1'b0;
      cyc(100);
      chk("skew1", 32'(p - p / 2), 32'((stp[0] - stp[1]) & 16'h001F));
      chk("skewd", 32'((15 - p - p / 2) & 31), 32'((stp[2] - stp[1]) & 16'h001F));
    end
    $display("t_phase done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {psel, pen, pwr, tick, lsync, std, paddr, pwdata} = '0;
    rst_n = 1'b0;
    cyc(5);
    rst_n <= 1'b1;
    cyc(4);
    t_reset;
    t_ratio;
    t_div;
    t_hiz;
    t_phase;
    complete_run;
  end
  // The tests need about 1150 cycles; this allows several times that.
  initial begin
    #400000;
    miscompares++;
    complete_run;
  end
endmodule
